// ===== verification/sims_ctrl_model.sv
// Behavioural memory controller that drives the device pins of sims_top.
// Assumes i_sys_clk from the bench; waits are counted in command clocks, except the strobe pulse, which is counted in i_sys_clk cycles.
`timescale 1ns/1ps
module sims_ctrl_model #(
  parameter int RST_LOW_NS  = 200000,
  parameter int CKE_WAIT_NS = 500000,
  parameter int XPR_CK      = 5
) (
  // System clock
  input  wire logic   i_sys_clk,
  // Device pins
  output logic        o_ck,
  output logic        o_reset_n,
  output logic        o_cke,
  output logic        o_term_en,
  output logic        o_dqs,
  output logic [3:0]  o_cmd,
  output logic [2:0]  o_bank,
  output logic [15:0] o_addr
);
  import sims_pkg::*;
  // ------------------------------------------------------------
  // Reset wait rounded up to whole command clocks, CKE wait rounded up less one
  // ------------------------------------------------------------
  localparam int CK_NS  = 160;
  localparam int RST_CK = (RST_LOW_NS + CK_NS - 1) / CK_NS;
  localparam int CKE_CK = (CKE_WAIT_NS + CK_NS - 1) / CK_NS - 1;
  // Odd start offset keeps command clock edges off the i_sys_clk edges
  initial begin
    o_ck = 1'b0;
    #7;
    forever #80 o_ck = ~o_ck;
  end
  // Termination left high in reset on purpose: the device must ignore it
  initial begin
    o_reset_n = 1'b0;
    o_cke     = 1'b0;
    o_term_en = 1'b1;
    o_dqs     = 1'b0;
    o_cmd     = SIMS_CMD_NOP;
    o_bank    = 3'h0;
    o_addr    = 16'h0000;
  end
  task automatic ck_wait(input int n);
    repeat (n) @(negedge o_ck);
  endtask
  task automatic hold_reset();
    o_reset_n <= 1'b0;
    o_cke     <= 1'b0;
    ck_wait(RST_CK);
  endtask
  task automatic release_reset();
    o_reset_n <= 1'b1;
    ck_wait(CKE_CK);
  endtask
  task automatic gate_clock();
    o_term_en <= 1'b0;
    ck_wait(5);
    o_cke <= 1'b1;
    ck_wait(XPR_CK);
  endtask
  // Banks are never opened here, so each mode-set finds them precharged
  task automatic cmd_out(input logic [3:0] c, input logic [2:0] b, input logic [15:0] a,
                         input int gap);
    ck_wait(1);
    o_cmd  <= c;
    o_bank <= b;
    o_addr <= a;
    ck_wait(1);
    o_cmd  <= SIMS_CMD_NOP;
    o_bank <= ~b;
    o_addr <= ~a;
    ck_wait(gap - 1);
  endtask
  task automatic level_enter(input logic [15:0] mr1);
    cmd_out(SIMS_CMD_MODE_SET, 3'h1, mr1, 12);
    o_term_en <= 1'b1;
    ck_wait(2);
  endtask
  // Strobe launched just after a chosen clock phase, so the capture is known
  task automatic strobe(input logic on_high);
    if (on_high) begin
      @(posedge o_ck);
    end else begin
      @(negedge o_ck);
    end
    @(posedge i_sys_clk);
    o_dqs <= 1'b1;
    repeat (8) @(posedge i_sys_clk);
    o_dqs <= 1'b0;
  endtask
  task automatic level_exit(input logic [15:0] mr1);
    ck_wait(2);
    o_term_en <= 1'b0;
    ck_wait(4);
    cmd_out(SIMS_CMD_MODE_SET, 3'h1, mr1, 4);
  endtask
endmodule

// ===== verification/sims_top_tb.sv
// Self-checking bench for sims_top: power-up, mode-set, leveling, registers.
// Assumes sims_ctrl_model as the far-side controller and the sims_pkg map.
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      num_errors++; \
      $display("[FAIL] %0t mismatch got %0h exp %0h", $time, (got), (exp)); \
    end \
  end
module sims_top_tb;
  import sims_pkg::*;
  logic clk, rst, ck, rst_n, cke, term_en, dqs, dq_oe, dq_valid, term_on, ready;
  logic [3:0]  cmd;
  logic [2:0]  bank;
  logic [15:0] addr, lv;
  logic [15:0] mr [4];
  logic [7:0]  dq;
  logic [ADDR_W-1:0] avs_addr;
  logic avs_rd, avs_wr, avs_wait, bit_lvl;
  logic [31:0] avs_wd, avs_rdata, rd, seed, zq;
  int num_errors, comparisons;
  always #10 clk = ~clk;
  sims_ctrl_model #(.RST_LOW_NS(4000), .CKE_WAIT_NS(8000)) ctrl_u (
    .i_sys_clk(clk), .o_ck(ck), .o_reset_n(rst_n), .o_cke(cke), .o_term_en(term_en),
    .o_dqs(dqs), .o_cmd(cmd), .o_bank(bank), .o_addr(addr));
  sims_top dut_u (
    .i_sys_clk(clk), .i_sys_rst(rst), .i_ck(ck), .i_reset_n(rst_n), .i_cke(cke),
    .i_term_en(term_en), .i_dqs(dqs), .i_cmd(cmd), .i_bank(bank), .i_addr(addr),
    .o_dq(dq), .o_dq_oe(dq_oe), .o_dq_valid(dq_valid), .o_term_on(term_on), .o_ready(ready),
    .i_avs_address(avs_addr), .i_avs_read(avs_rd), .i_avs_write(avs_wr),
    .i_avs_writedata(avs_wd), .o_avs_readdata(avs_rdata), .o_avs_waitrequest(avs_wait));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Loop reset bit reads back cleared once it has fired
  function automatic logic [31:0] exp_mode(input int idx, input logic [15:0] v);
    return (idx == 0) ? {16'h0, v & ~(16'h1 << MR0_DLL_RESET)} : {16'h0, v};
  endfunction
  function automatic logic [7:0] exp_dq(input logic lvl);
    return {7'h00, lvl};
  endfunction
  task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_addr <= a;
    avs_wr   <= wr;
    avs_rd   <= ~wr;
    avs_wd   <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avs_wait !== 1'b0 && n < 20);
    q = avs_rdata;
    avs_rd <= 1'b0;
    avs_wr <= 1'b0;
    if (n >= 20) begin
      num_errors++;
      $display("[FAIL] %0t bus hang", $time);
    end
  endtask
  task automatic chk_reg(input logic [4:0] a, input logic [31:0] exp);
    av(1'b0, a, xs(), rd);
    `CHK(rd, exp)
  endtask
  task automatic give_verdict();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    avs_addr = '0;
    avs_rd = 1'b0;
    avs_wr = 1'b0;
    avs_wd = 32'h0;
    seed = 32'he8c3;
    num_errors = 0;
    comparisons = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK(ready, 1'b0)
    chk_reg(OFS_CFG_MOD, 32'h0000000c);
    zq = 32'h2 + (xs() % 32'h8);
    av(1'b1, OFS_CFG_ZQ, zq, rd);
    chk_reg(OFS_CFG_ZQ, zq);
    ctrl_u.hold_reset();
    `CHK(term_on, 1'b0)
    ctrl_u.release_reset();
    `CHK(term_on, 1'b0)
    av(1'b0, OFS_STATUS, 32'h0, rd);
    `CHK(rd[ST_CKE_SEEN], 1'b0)
    ctrl_u.gate_clock();
    av(1'b0, OFS_STATUS, 32'h0, rd);
    `CHK(rd[ST_CKE_SEEN], 1'b1)
    for (int k = 0; k < 4; k++) begin
      rd = xs();
      mr[k] = rd[15:0];
    end
    mr[1] = (mr[1] & ~16'h1284) | 16'h0004;
    mr[0] = mr[0] | 16'h0100;
    ctrl_u.cmd_out(SIMS_CMD_MODE_SET, 3'b010, mr[2], 4);
    ctrl_u.cmd_out(SIMS_CMD_MODE_SET, 3'b011, mr[3], 4);
    ctrl_u.cmd_out(SIMS_CMD_MODE_SET, 3'b001, mr[1], 4);
    // Gap after the latency change also covers the slow power-down exit
    ctrl_u.cmd_out(SIMS_CMD_MODE_SET, 3'b000, mr[0], 12);
    ctrl_u.cmd_out(SIMS_CMD_ZQ, 3'b000, 16'h1 << ZQ_LONG_BIT, 1);
    for (int k = 0; k < 4; k++) chk_reg(OFS_MODE_BASE + 5'(4 * k), exp_mode(k, mr[k]));
    ctrl_u.ck_wait(470);
    `CHK(ready, 1'b0)
    ctrl_u.ck_wait(40);
    `CHK(ready, 1'b1)
    chk_reg(OFS_ERR, 32'h0);
    // Deliberately early commands must be flagged
    ctrl_u.cmd_out(SIMS_CMD_MODE_SET, 3'b010, mr[2], 1);
    ctrl_u.cmd_out(SIMS_CMD_MODE_SET, 3'b011, mr[3], 4);
    ctrl_u.cmd_out(SIMS_CMD_ZQ, 3'b000, 16'h1 << ZQ_LONG_BIT, 20);
    chk_reg(OFS_ERR, 32'h3);
    av(1'b1, OFS_ERR, 32'h3, rd);
    chk_reg(OFS_ERR, 32'h0);
    lv = (mr[1] | 16'h0080) & ~16'h1000;
    ctrl_u.level_enter(lv);
    av(1'b0, OFS_STATUS, 32'h0, rd);
    `CHK(rd[ST_LEVELING], 1'b1)
    `CHK(dq_oe, 1'b1)
    `CHK(term_on, 1'b1)
    for (int i = 0; i < 4; i++) begin
      rd = xs();
      bit_lvl = (i < 2) ? i[0] : rd[0];
      ctrl_u.strobe(bit_lvl);
      repeat (4) @(posedge clk);
      `CHK(dq, exp_dq(bit_lvl))
    end
    ctrl_u.level_exit(mr[1]);
    `CHK(dq_oe, 1'b1)
    `CHK(dq_valid, 1'b0)
    `CHK(term_on, 1'b0)
    ctrl_u.ck_wait(12);
    `CHK(dq_oe, 1'b0)
    `CHK(ready, 1'b1)
    av(1'b0, OFS_STATUS, 32'h0, rd);
    `CHK(rd[ST_LEVELING], 1'b0)
    chk_reg(OFS_MODE_BASE + 5'h04, {16'h0, mr[1]});
    ctrl_u.hold_reset();
    chk_reg(OFS_MODE_BASE + 5'h04, 32'h0);
    `CHK(ready, 1'b0)
    give_verdict();
  end
  // Whole run is about 730 command clocks; the limit of 2500 allows over three times that
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    give_verdict();
  end
endmodule

// ===== verilog/sims_link_if.sv
// Sampled command-pin bundle between the pin sampler and the core.
// Assumes both ends run on the system clock.
`timescale 1ns/1ps
interface sims_link_if;
  logic        ck_rise;
  logic        ck_lvl;
  logic        reset_n;
  logic        cke;
  logic        term_en;
  logic        dqs_rise;
  logic        dqs;
  logic [3:0]  cmd;
  logic [2:0]  bank;
  logic [15:0] addr;
  modport sampler (output ck_rise, ck_lvl, reset_n, cke, term_en, dqs_rise, dqs, cmd, bank, addr);
  modport core    (input  ck_rise, ck_lvl, reset_n, cke, term_en, dqs_rise, dqs, cmd, bank, addr);
endinterface

// ===== verilog/sims_link_sampler.sv
// Two-stage synchroniser for all device pins plus edge finding.
// Assumes pins are asynchronous to i_sys_clk and much slower than it.
`timescale 1ns/1ps
module sims_link_sampler (
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_sys_rst,
  // Raw pins
  input  wire logic        i_ck,
  input  wire logic        i_reset_n,
  input  wire logic        i_cke,
  input  wire logic        i_term_en,
  input  wire logic        i_dqs,
  input  wire logic [3:0]  i_cmd,
  input  wire logic [2:0]  i_bank,
  input  wire logic [15:0] i_addr,
  // Sampled side
  sims_link_if.sampler     link
);
  // Pin bundle width: ck, reset_n, cke, term_en, dqs, 4 cmd, 3 bank, 16 addr
  localparam int PW = 28;
  logic [PW-1:0] raw;
  logic [PW-1:0] s1_q;
  logic [PW-1:0] s2_q;
  logic          ck_old_q;
  logic          dqs_old_q;

  assign raw = {i_ck, i_reset_n, i_cke, i_term_en, i_dqs, i_cmd, i_bank, i_addr};

  // Edge detectors look only at the second stage
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      s1_q      <= '0;
      s2_q      <= '0;
      ck_old_q  <= 1'b0;
      dqs_old_q <= 1'b0;
    end else begin
      s1_q      <= raw;
      s2_q      <= s1_q;
      ck_old_q  <= s2_q[27];
      dqs_old_q <= s2_q[23];
    end
  end

  assign link.ck_lvl   = s2_q[27];
  assign link.ck_rise  = s2_q[27] & ~ck_old_q;
  assign link.reset_n  = s2_q[26];
  assign link.cke      = s2_q[25];
  assign link.term_en  = s2_q[24];
  assign link.dqs      = s2_q[23];
  assign link.dqs_rise = s2_q[23] & ~dqs_old_q;
  assign link.cmd      = s2_q[22:19];
  assign link.bank     = s2_q[18:16];
  assign link.addr     = s2_q[15:0];
endmodule

// ===== verilog/sims_pkg.sv
// Constants shared by the power-up and mode-set tracking logic.
// Assumes a single 50 MHz system clock and a slower sampled command clock.
package sims_pkg;
  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int          ADDR_W        = 5;
  localparam logic [4:0]  OFS_STATUS    = 5'h00;
  localparam logic [4:0]  OFS_ERR       = 5'h04;
  localparam logic [4:0]  OFS_CFG_MOD   = 5'h08;
  localparam logic [4:0]  OFS_CFG_ZQ    = 5'h0c;
  localparam logic [4:0]  OFS_MODE_BASE = 5'h10;
  // ---------------------------------------------------------------
  // Status and error bits
  // ---------------------------------------------------------------
  localparam int ST_READY    = 0;
  localparam int ST_CKE_SEEN = 1;
  localparam int ST_DLL_DONE = 2;
  localparam int ST_ZQ_DONE  = 3;
  localparam int ST_MOD_BUSY = 4;
  localparam int ST_LEVELING = 5;
  localparam int ST_TERM_ON  = 6;
  localparam int ERR_CMD_MOD = 0;
  localparam int ERR_MRS_MRD = 1;
  localparam int ERR_W       = 2;
  // ---------------------------------------------------------------
  // Mode register fields
  // ---------------------------------------------------------------
  localparam int MODE_W        = 16;
  localparam int MR0_DLL_RESET = 8;
  localparam int MR1_LEVELING  = 7;
  localparam int MR1_QOFF      = 12;
  localparam int MR1_RTT_B0    = 2;
  localparam int MR1_RTT_B1    = 6;
  localparam int MR1_RTT_B2    = 9;
  localparam int ZQ_LONG_BIT   = 10;
  localparam int PRIME_DQ      = 0;
  // ---------------------------------------------------------------
  // Timing in command-clock cycles
  // ---------------------------------------------------------------
  localparam int          CNT_W        = 12;
  localparam logic [11:0] DLL_LOCK_CYC = 12'h200;
  localparam logic [11:0] MOD_DEF_CYC  = 12'h00c;
  localparam logic [11:0] MRD_DEF_CYC  = 12'h004;
  localparam logic [11:0] ZQ_DEF_CYC   = 12'h200;
  // ---------------------------------------------------------------
  // Command encoding {cs_n, ras_n, cas_n, we_n}
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    SIMS_CMD_MODE_SET = 4'b0000,
    SIMS_CMD_ZQ       = 4'b0110,
    SIMS_CMD_NOP      = 4'b0111
  } sims_cmd_t;
endpackage

// ===== verilog/sims_top.sv
// Device-side power-up, mode-set and leveling-exit tracking.
// Assumes an Avalon-MM master on i_sys_clk and pins sampled by that clock.
`timescale 1ns/1ps
module sims_top #(
  parameter logic [11:0] MRD_CYC = sims_pkg::MRD_DEF_CYC
) (
  // Clock and reset
  input  wire logic                       i_sys_clk,
  input  wire logic                       i_sys_rst,
  // Device pins
  input  wire logic                       i_ck,
  input  wire logic                       i_reset_n,
  input  wire logic                       i_cke,
  input  wire logic                       i_term_en,
  input  wire logic                       i_dqs,
  input  wire logic [3:0]                 i_cmd,
  input  wire logic [2:0]                 i_bank,
  input  wire logic [15:0]                i_addr,
  output logic [7:0]                      o_dq,
  output logic                            o_dq_oe,
  output logic                            o_dq_valid,
  output logic                            o_term_on,
  output logic                            o_ready,
  // Avalon-MM slave
  input  wire logic [sims_pkg::ADDR_W-1:0] i_avs_address,
  input  wire logic                       i_avs_read,
  input  wire logic                       i_avs_write,
  input  wire logic [31:0]                i_avs_writedata,
  output logic [31:0]                     o_avs_readdata,
  output logic                            o_avs_waitrequest
);
  import sims_pkg::*;

  sims_link_if link ();

  sims_link_sampler u_sampler (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_ck      (i_ck),
    .i_reset_n (i_reset_n),
    .i_cke     (i_cke),
    .i_term_en (i_term_en),
    .i_dqs     (i_dqs),
    .i_cmd     (i_cmd),
    .i_bank    (i_bank),
    .i_addr    (i_addr),
    .link      (link)
  );

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  logic [MODE_W-1:0] mode_q [4];
  logic              cke_seen_q;
  logic [CNT_W-1:0]  mod_cnt_q, mrd_cnt_q, dll_cnt_q, zq_cnt_q;
  logic              dll_started_q, zq_started_q, exit_pend_q;
  logic [7:0]        dq_q;
  logic [ERR_W-1:0]  err_q;
  logic [CNT_W-1:0]  cfg_mod_q, cfg_zq_q;

  wire dev_rst   = ~link.reset_n;
  wire cmd_edge  = link.ck_rise & link.cke & cke_seen_q;
  wire is_mrs    = cmd_edge & (link.cmd == SIMS_CMD_MODE_SET);
  wire is_zql    = cmd_edge & (link.cmd == SIMS_CMD_ZQ) & link.addr[ZQ_LONG_BIT];
  wire is_idle   = link.cmd[3] | (link.cmd == SIMS_CMD_NOP);
  wire is_busy   = cmd_edge & ~is_idle & ~is_mrs;
  wire mod_busy  = mod_cnt_q != '0;
  wire mrd_busy  = mrd_cnt_q != '0;
  wire dll_rst   = is_mrs & (link.bank[1:0] == 2'b00) & link.addr[MR0_DLL_RESET];
  wire leveling  = mode_q[1][MR1_LEVELING];
  wire lvl_exit  = is_mrs & (link.bank[1:0] == 2'b01) & leveling & ~link.addr[MR1_LEVELING];
  wire rtt_nom   = mode_q[1][MR1_RTT_B0] | mode_q[1][MR1_RTT_B1] | mode_q[1][MR1_RTT_B2];
  wire dll_done  = dll_started_q & (dll_cnt_q == '0);
  wire zq_done   = zq_started_q & (zq_cnt_q == '0);

  // Down-counter step on command-clock edges, reload on trigger
  function automatic logic [CNT_W-1:0] step(input logic [CNT_W-1:0] cnt,
                                            input logic load, input logic [CNT_W-1:0] val,
                                            input logic tick);
    if (load) step = val;
    else if (tick && cnt != '0) step = cnt - 1'b1;
    else step = cnt;
  endfunction

  // ---------------------------------------------------------------
  // Mode registers and clock-gate tracking
  // ---------------------------------------------------------------
  // Only the mode registers and cke_seen_q are written here; no array state exists.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || dev_rst) begin
      for (int i = 0; i < 4; i++) mode_q[i] <= '0;
      cke_seen_q <= 1'b0;
    end else begin
      if (link.ck_rise && link.cke) cke_seen_q <= 1'b1;
      if (link.ck_rise && mode_q[0][MR0_DLL_RESET])
        mode_q[0][MR0_DLL_RESET] <= 1'b0;
      if (is_mrs) mode_q[link.bank[1:0]] <= link.addr;
    end
  end

  // ---------------------------------------------------------------
  // Delay tracking: update, mode-to-mode, loop lock, calibration
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || dev_rst) begin
      mod_cnt_q     <= '0;
      mrd_cnt_q     <= '0;
      dll_cnt_q     <= '0;
      zq_cnt_q      <= '0;
      dll_started_q <= 1'b0;
      zq_started_q  <= 1'b0;
      exit_pend_q   <= 1'b0;
    end else begin
      mod_cnt_q <= step(mod_cnt_q, is_mrs, cfg_mod_q, link.ck_rise);
      mrd_cnt_q <= step(mrd_cnt_q, is_mrs, MRD_CYC, link.ck_rise);
      dll_cnt_q <= step(dll_cnt_q, dll_rst, DLL_LOCK_CYC, link.ck_rise);
      zq_cnt_q  <= step(zq_cnt_q, is_zql, cfg_zq_q, link.ck_rise);
      if (dll_rst) dll_started_q <= 1'b1;
      if (is_zql)  zq_started_q  <= 1'b1;
      if (lvl_exit) exit_pend_q <= 1'b1;
      else if (!mod_busy) exit_pend_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Leveling feedback and pin outputs
  // ---------------------------------------------------------------
  // While leveling, prime line reports the clock level seen at each strobe rise
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || dev_rst) begin
      dq_q <= '0;
    end else if (leveling && link.dqs_rise) begin
      dq_q           <= '0;
      dq_q[PRIME_DQ] <= link.ck_lvl;
    end
  end

  assign o_dq       = dq_q;
  assign o_dq_oe    = (leveling | exit_pend_q) & ~mode_q[1][MR1_QOFF];
  assign o_dq_valid = leveling & ~exit_pend_q & link.dqs;
  // Termination stays high-Z in reset and until clock gate seen
  assign o_term_on  = ~dev_rst & cke_seen_q & link.term_en & rtt_nom;
  assign o_ready    = dll_done & zq_done & ~mod_busy;

  // ---------------------------------------------------------------
  // Avalon-MM slave, one wait state on every access
  // ---------------------------------------------------------------
  logic        ack_q;
  logic [31:0] rdata_q;
  wire         req     = i_avs_read | i_avs_write;
  wire         wr_take = i_avs_write & ack_q;
  wire [ERR_W-1:0] err_set = {is_mrs & mrd_busy, is_busy & mod_busy};
  wire [ERR_W-1:0] err_clr = (wr_take && i_avs_address == OFS_ERR) ?
                             i_avs_writedata[ERR_W-1:0] : '0;
  wire [31:0]  status  = {25'h0000000, cke_seen_q & o_term_on, leveling, mod_busy,
                          zq_done, dll_done, cke_seen_q, o_ready};
  wire [1:0]   mr_idx  = i_avs_address[3:2];
  wire [31:0]  rd_mux  =
    (i_avs_address == OFS_STATUS)  ? status :
    (i_avs_address == OFS_ERR)     ? {30'h00000000, err_q} :
    (i_avs_address == OFS_CFG_MOD) ? {20'h00000, cfg_mod_q} :
    (i_avs_address == OFS_CFG_ZQ)  ? {20'h00000, cfg_zq_q} :
    (i_avs_address[4] && i_avs_address[1:0] == 2'b00) ? {16'h0000, mode_q[mr_idx]} :
    32'h00000000;

  assign o_avs_waitrequest = req & ~ack_q;
  assign o_avs_readdata    = rdata_q;

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      ack_q     <= 1'b0;
      rdata_q   <= '0;
      err_q     <= '0;
      cfg_mod_q <= MOD_DEF_CYC;
      cfg_zq_q  <= ZQ_DEF_CYC;
    end else begin
      ack_q <= req & ~ack_q;
      if (i_avs_read && !ack_q) rdata_q <= rd_mux;
      // Set beats clear in the same cycle
      err_q <= (err_q & ~err_clr) | err_set;
      if (wr_take && i_avs_address == OFS_CFG_MOD) cfg_mod_q <= i_avs_writedata[CNT_W-1:0];
      if (wr_take && i_avs_address == OFS_CFG_ZQ)  cfg_zq_q  <= i_avs_writedata[CNT_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  property p_mode_clear;
    dev_rst |=> (mode_q[0] == '0) && (mode_q[1] == '0) && !o_ready;
  endproperty
  a_mode_clear: assert property (p_mode_clear) else $error("mode regs kept in reset");

  property p_dll_selfclear;
    $rose(mode_q[0][MR0_DLL_RESET]) && !dev_rst |-> ##[1:20] !mode_q[0][MR0_DLL_RESET];
  endproperty
  a_dll_selfclear: assert property (p_dll_selfclear) else $error("loop reset bit stuck");

  property p_term_hiz;
    (dev_rst || !cke_seen_q) |-> !o_term_on;
  endproperty
  a_term_hiz: assert property (p_term_hiz) else $error("termination on too early");

  property p_cmd_in_mod;
    (is_busy && mod_busy) |=> err_q[ERR_CMD_MOD];
  endproperty
  a_cmd_in_mod: assert property (p_cmd_in_mod) else $error("early command not flagged");

  property p_mrs_in_mrd;
    (is_mrs && mrd_busy && !dev_rst) |=> err_q[ERR_MRS_MRD];
  endproperty
  a_mrs_in_mrd: assert property (p_mrs_in_mrd) else $error("early mode-set not flagged");

  property p_dll_wait;
    dll_rst && !dev_rst |=> !dll_done && (dll_cnt_q == DLL_LOCK_CYC);
  endproperty
  a_dll_wait: assert property (p_dll_wait) else $error("lock wait not started");

  property p_ready_cause;
    o_ready |-> dll_done && zq_done && !mod_busy;
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("ready too early");

  property p_exit_undef;
    lvl_exit && !dev_rst |=> !o_dq_valid && exit_pend_q;
  endproperty
  a_exit_undef: assert property (p_exit_undef) else $error("data valid after exit");

  property p_lvl_entry;
    is_mrs && !dev_rst && link.bank[1:0] == 2'b01 |=> leveling == $past(link.addr[MR1_LEVELING]);
  endproperty
  a_lvl_entry: assert property (p_lvl_entry) else $error("leveling bit not tracked");
endmodule
